/* File: ssadc_pkg.sv */
// package of constants and types for the single slope converter timer
package ssadc_pkg;

  // ==========================================================
  // register map (word index on the plain register port)
  localparam logic [3:0] OFF_MODE_CTRL  = 4'h0;
  localparam logic [3:0] OFF_SYNC_WIDTH = 4'h1;
  localparam logic [3:0] OFF_TRIM       = 4'h2;
  localparam logic [3:0] OFF_RESULT1    = 4'h3;
  localparam logic [3:0] OFF_RESULT2    = 4'h4;
  localparam logic [3:0] OFF_RESULT3    = 4'h5;
  localparam logic [3:0] OFF_RESULTAUX  = 4'h6;
  localparam logic [3:0] OFF_STATUS     = 4'h7;

  // ==========================================================
  // mode control fields
  localparam int MODE_RATE_BIT  = 7;
  localparam int MODE_AUXHI_BIT = 5;
  localparam int MODE_AUXMD_BIT = 1;
  localparam int MODE_AUXLO_BIT = 0;
  localparam int MODE_DOUBLE_BIT = 9;

  // ==========================================================
  // reset values and widths
  localparam logic [15:0] MODE_RESET       = 16'h0000;
  localparam logic [15:0] SYNC_WIDTH_RESET = 16'h0028;
  localparam logic [2:0]  TRIM_RESET       = 3'h0;
  localparam logic [11:0] COUNT_SAT        = 12'hFFF;
  localparam logic [2:0]  AUX_CAL_CODE     = 3'h3;
  localparam int          NUM_CHAN         = 4;

  // ==========================================================
  // timing: core clock 10 MHz
  localparam int CORE_PERIOD_NS = 100;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_RESET = 2'b01,
    ST_RAMP  = 2'b11
  } ramp_state_type;

  typedef struct packed
  {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

endpackage

/* File: ramp_timer.sv */
// shared ramp timer with rate select and saturation
`timescale 1ns/100ps

module ramp_timer
  import ssadc_pkg::*;
#(
  parameter int CNT_W = 12
)
(
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             clkEn,
  input  wire logic             clear,
  input  wire logic             fastRate,
  output logic      [CNT_W-1:0] count
);

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             phase_r;
  logic             phase_nxt;

  // ==========================================================
  // counting
  always_comb
  begin
    count_nxt = count_r;
    phase_nxt = ~phase_r;
    if (clear)
    begin
      count_nxt = '0; // RL13
      phase_nxt = 1'b0;
    end
    else if ((fastRate || phase_r) && count_r != COUNT_SAT) // RL5 RL6
    begin
      count_nxt = count_r + 1'b1; // RL1
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      count_r <= '0;
      phase_r <= 1'b0;
    end
    else if (clkEn)
    begin
      count_r <= count_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign count = count_r;

  chk_count_saturate : assert property ( // RL6
    @(posedge core_clk) disable iff (!nrst)
    clkEn && !clear && count_r == COUNT_SAT |=> count_r == COUNT_SAT)
    else $error("timer passed saturation");
  chk_slow_rate : assert property ( // RL5
    @(posedge core_clk) disable iff (!nrst)
    clkEn && !clear && !fastRate && !phase_r |=> $stable(count_r))
    else $error("slow rate counted on even phase");

endmodule

/* File: ssadc_timer.sv */
// single slope converter control: sync, capture, mux and trim
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps

// Behaviour
// RL1 - each conversion is the elapsed count of a 12-bit timer kept as result.
// RL2 - the sync pulse resets the ramp and starts each conversion cycle.
// RL3 - the sync pulse width comes from a programmable width register.
// RL4 - four comparators share one timer, each latching its own result.
// RL5 - rate bit clear counts at half core rate, set counts at core rate.
// RL6 - the count saturates at 4095.
// RL7 - double update mode halves the effective period for the count limit.
// RL8 - auxiliary select is bits 5, 1, 0 with code 011 the reference.
// RL9 - a 3-bit trim sets the ramp current, resetting to zero.
// RL10 - a channel that never trips in a cycle reads as zero.
// RL11 - all four channels convert together in the same ramp cycle.
// RL12 - a result captured while still acquiring has its low bit forced high.
// RL13 - the timer holds at zero during the sync pulse and counts after it.
module ssadc_timer
  import ssadc_pkg::*;
#(
  parameter int CNT_W = 12
)
(
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 clkEn,
  input  wire logic                 periodStart,
  input  wire logic [NUM_CHAN-1:0]  compTrip,
  input  wire logic [NUM_CHAN-1:0]  chanAcquiring,
  input  wire ssadc_pkg::reg_req_type regReq,
  output logic      [15:0]          regRdata,
  output logic                      period_sync_pulse,
  output logic                      rampReset,
  output logic      [2:0]           ramp_current_trim,
  output logic      [2:0]           auxSelect,
  output logic                      timer_rate_select
);
  import ssadc_pkg::*;

  logic [15:0]          mode_control_reg_r, mode_control_reg_nxt;
  logic [15:0]          syncWidth_r, syncWidth_nxt;
  logic [2:0]           trim_r, trim_nxt;
  logic [15:0]          rdata_r, rdata_nxt;
  logic [CNT_W-1:0]     result_r [NUM_CHAN];
  logic [CNT_W-1:0]     result_nxt [NUM_CHAN];
  logic [NUM_CHAN-1:0]  tripped_r, tripped_nxt;
  logic [15:0]          syncCnt_r, syncCnt_nxt;
  ramp_state_type       state_r, state_nxt;
  logic                 sync_r, sync_nxt;
  logic                 rst_r, rst_nxt;
  logic [2:0]           aux_r, aux_nxt;
  logic                 rate_r, rate_nxt;
  logic [CNT_W-1:0]     count;
  logic                 timerClear;

  // ==========================================================
  // shared timer
  // clear on both sides of the pulse: the first ramp cycle reads zero
  assign timerClear = (state_r != ST_RAMP) || (state_nxt != ST_RAMP); // RL13

  ramp_timer #(.CNT_W(CNT_W)) timerInst
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clkEn    (clkEn),
    .clear    (timerClear),
    .fastRate (mode_control_reg_r[MODE_RATE_BIT]),
    .count    (count)
  );

  // ==========================================================
  // sync pulse sequencing
  always_comb
  begin
    state_nxt   = state_r;
    syncCnt_nxt = syncCnt_r;
    sync_nxt    = 1'b0;
    case (state_r)
      ST_IDLE, ST_RAMP:
      begin
        if (periodStart) // RL2
        begin
          state_nxt   = ST_RESET;
          syncCnt_nxt = syncWidth_r; // RL3
          sync_nxt    = 1'b1;
        end
      end
      ST_RESET:
      begin
        if (syncCnt_r <= 16'h0001)
        begin
          state_nxt = ST_RAMP;
        end
        else
        begin
          syncCnt_nxt = syncCnt_r - 16'h0001;
          sync_nxt    = 1'b1;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    rst_nxt = sync_nxt; // RL2
  end

  // ==========================================================
  // result capture per channel
  // the limit of a cycle is the next sync, so double update mode (shorter
  // period of sync pulses) shortens the reachable count on its own
  for (genvar c = 0; c < NUM_CHAN; c++)
  begin : g_chan
    always_comb
    begin
      result_nxt[c]  = result_r[c];
      tripped_nxt[c] = tripped_r[c];
      if (state_r == ST_RAMP && state_nxt == ST_RESET)
      begin
        tripped_nxt[c] = 1'b0;
        if (!tripped_r[c])
        begin
          result_nxt[c] = '0; // RL10 RL7
        end
      end
      else if (state_r == ST_RAMP && compTrip[c] && !tripped_r[c])
      begin
        tripped_nxt[c] = 1'b1; // RL4 RL11
        result_nxt[c]  = count; // RL1
        if (chanAcquiring[c])
        begin
          result_nxt[c][0] = 1'b1; // RL12
        end
      end
    end
  end

  // ==========================================================
  // register port
  always_comb
  begin
    mode_control_reg_nxt  = mode_control_reg_r;
    syncWidth_nxt = syncWidth_r;
    trim_nxt      = trim_r;
    rdata_nxt     = 16'h0000;
    if (regReq.wr)
    begin
      if (regReq.addr == OFF_MODE_CTRL)
        mode_control_reg_nxt = regReq.wdata;
      else if (regReq.addr == OFF_SYNC_WIDTH)
        syncWidth_nxt = regReq.wdata; // RL3
      else if (regReq.addr == OFF_TRIM)
        trim_nxt = regReq.wdata[2:0]; // RL9
    end
    if (regReq.rd)
    begin
      if (regReq.addr == OFF_MODE_CTRL)
        rdata_nxt = mode_control_reg_r;
      else if (regReq.addr == OFF_SYNC_WIDTH)
        rdata_nxt = syncWidth_r;
      else if (regReq.addr == OFF_TRIM)
        rdata_nxt = {13'h0, trim_r};
      else if (regReq.addr == OFF_RESULT1)
        rdata_nxt = {4'h0, result_r[0]};
      else if (regReq.addr == OFF_RESULT2)
        rdata_nxt = {4'h0, result_r[1]};
      else if (regReq.addr == OFF_RESULT3)
        rdata_nxt = {4'h0, result_r[2]};
      else if (regReq.addr == OFF_RESULTAUX)
        rdata_nxt = {4'h0, result_r[3]};
      else if (regReq.addr == OFF_STATUS)
        rdata_nxt = {10'h0, state_r, tripped_r};
    end
    aux_nxt = {mode_control_reg_nxt[MODE_AUXHI_BIT], mode_control_reg_nxt[MODE_AUXMD_BIT],
               mode_control_reg_nxt[MODE_AUXLO_BIT]}; // RL8
    rate_nxt = mode_control_reg_nxt[MODE_RATE_BIT]; // RL5
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      mode_control_reg_r  <= MODE_RESET;
      syncWidth_r <= SYNC_WIDTH_RESET;
      trim_r      <= TRIM_RESET; // RL9
      rdata_r     <= 16'h0000;
      state_r     <= ST_IDLE;
      syncCnt_r   <= 16'h0000;
      sync_r      <= 1'b0;
      rst_r       <= 1'b0;
      aux_r       <= 3'h0;
      rate_r      <= 1'b0;
      tripped_r   <= '0;
      for (int i = 0; i < NUM_CHAN; i++)
        result_r[i] <= '0;
    end
    else if (clkEn)
    begin
      mode_control_reg_r  <= mode_control_reg_nxt;
      syncWidth_r <= syncWidth_nxt;
      trim_r      <= trim_nxt;
      rdata_r     <= rdata_nxt;
      state_r     <= state_nxt;
      syncCnt_r   <= syncCnt_nxt;
      sync_r      <= sync_nxt;
      rst_r       <= rst_nxt;
      aux_r       <= aux_nxt;
      rate_r      <= rate_nxt;
      tripped_r   <= tripped_nxt;
      for (int i = 0; i < NUM_CHAN; i++)
        result_r[i] <= result_nxt[i];
    end
  end

  assign regRdata          = rdata_r;
  assign period_sync_pulse = sync_r;
  assign rampReset         = rst_r;
  assign ramp_current_trim = trim_r;
  assign auxSelect         = aux_r;
  assign timer_rate_select = rate_r;

  // ==========================================================
  // checks
  chk_sync_start : assert property ( // RL2
    @(posedge core_clk) disable iff (!nrst)
    clkEn && periodStart && state_r != ST_RESET |=> sync_r && rst_r)
    else $error("sync pulse did not start");
  chk_timer_held : assert property ( // RL13
    @(posedge core_clk) disable iff (!nrst)
    sync_r |-> count == '0)
    else $error("timer ran during sync");
  chk_capture_val : assert property ( // RL1 RL4
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r == ST_RAMP && state_nxt == ST_RAMP && compTrip[0]
    && !tripped_r[0] && !chanAcquiring[0]
    |=> result_r[0] == $past(count))
    else $error("channel one capture wrong");
  chk_capture_aux : assert property ( // RL11
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r == ST_RAMP && state_nxt == ST_RAMP && compTrip[3]
    && !tripped_r[3] |=> tripped_r[3])
    else $error("aux channel missed its trip");
  chk_invalid_lsb : assert property ( // RL12
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r == ST_RAMP && state_nxt == ST_RAMP && compTrip[1]
    && !tripped_r[1] && chanAcquiring[1] |=> result_r[1][0])
    else $error("acquiring result lacks low bit");
  chk_no_trip_zero : assert property ( // RL10 RL7
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r == ST_RAMP && state_nxt == ST_RESET && !tripped_r[2]
    |=> result_r[2] == '0)
    else $error("untripped channel not zero");
  chk_width_hold : assert property ( // RL3
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r == ST_RESET && syncCnt_r > 16'h0001 |=> sync_r)
    else $error("sync pulse ended early");
  chk_aux_code : assert property ( // RL8
    @(posedge core_clk) disable iff (!nrst)
    clkEn && regReq.wr && regReq.addr == OFF_MODE_CTRL
    |=> auxSelect == {$past(regReq.wdata[5]), $past(regReq.wdata[1:0])})
    else $error("aux select not from mode bits");
  chk_trim_write : assert property ( // RL9
    @(posedge core_clk) disable iff (!nrst)
    clkEn && regReq.wr && regReq.addr == OFF_TRIM
    |=> ramp_current_trim == $past(regReq.wdata[2:0]))
    else $error("trim not written");
  // a start inside the pulse would shorten the ramp discharge
  chk_start_refused : assert property ( // RL2
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r == ST_RESET && syncCnt_r > 16'h0001
    |=> state_r == ST_RESET)
    else $error("period start cut the sync pulse");
  chk_width_load : assert property ( // RL3
    @(posedge core_clk) disable iff (!nrst)
    clkEn && periodStart && state_r != ST_RESET
    |=> syncCnt_r == $past(syncWidth_r))
    else $error("sync width not loaded");
  chk_width_end : assert property ( // RL3
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r == ST_RESET && syncCnt_r <= 16'h0001
    |=> !sync_r && state_r == ST_RAMP)
    else $error("sync pulse ran too long");
  // every channel of a cycle must share the same zero
  chk_timer_origin : assert property ( // RL13
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r == ST_RESET && syncCnt_r <= 16'h0001
    |=> count == '0)
    else $error("timer not at zero on ramp start");
  chk_trip_once : assert property ( // RL4
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r == ST_RAMP && state_nxt == ST_RAMP && tripped_r[2]
    |=> $stable(result_r[2]))
    else $error("second trip overwrote result");
  chk_aux_value : assert property ( // RL11
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r == ST_RAMP && state_nxt == ST_RAMP && compTrip[3]
    && !tripped_r[3] && !chanAcquiring[3] |=> result_r[3] == $past(count))
    else $error("aux channel capture wrong");
  chk_flags_clear : assert property ( // RL10
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r == ST_RAMP && state_nxt == ST_RESET
    |=> tripped_r == '0)
    else $error("trip flags kept over a new cycle");
  chk_idle_hold : assert property ( // RL4
    @(posedge core_clk) disable iff (!nrst)
    clkEn && state_r != ST_RAMP
    |=> $stable(result_r[0]))
    else $error("result changed outside the ramp");
  chk_rate_write : assert property ( // RL5
    @(posedge core_clk) disable iff (!nrst)
    clkEn && regReq.wr && regReq.addr == OFF_MODE_CTRL
    |=> timer_rate_select == $past(regReq.wdata[MODE_RATE_BIT]))
    else $error("rate select not from mode bit");
  chk_trim_hold : assert property ( // RL9
    @(posedge core_clk) disable iff (!nrst)
    clkEn && !(regReq.wr && regReq.addr == OFF_TRIM)
    |=> $stable(ramp_current_trim))
    else $error("trim changed without a write");
  chk_frozen_state : assert property ( // RL13
    @(posedge core_clk) disable iff (!nrst)
    !clkEn
    |=> $stable(state_r) && $stable(syncCnt_r) && $stable(count))
    else $error("state moved with clock enable low");

endmodule

/* File: ssadc_front.sv */
// behavioural comparators, ramp capacitor and period sync source
`timescale 1ns/100ps

module ssadc_front
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       rampReset,
  input  int              period,
  input  int              thr [4],
  output logic            periodStart,
  output logic [3:0]      compTrip
);
  int pc = 0;
  int ramp = 0;

  initial
  begin
    periodStart = 1'b0;
    compTrip = 4'h0;
  end

  // ==========================================================
  // sync source and ramp
  always @(posedge core_clk)
  begin
    pc <= (!nrst || pc + 1 >= period) ? 0 : pc + 1;
    periodStart <= nrst && pc == 0;
    // ramp reads zero from the second cycle of the reset pulse, so it is fully discharged
    ramp <= rampReset ? 0 : ramp + 1;
    for (int i = 0; i < 4; i++)
      compTrip[i] <= !rampReset && ramp >= thr[i];
  end
endmodule

/* File: ssadc_timer_tb.sv */
// self-checking bench for the single slope converter timer
`timescale 1ns/100ps

module ssadc_timer_tb;
  import ssadc_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clkEn = 1'b1;
  logic        periodStart;
  logic [3:0]  compTrip;
  logic [3:0]  chanAcquiring = 4'h0;
  reg_req_type regReq = '0;
  logic [15:0] regRdata;
  logic        period_sync_pulse;
  logic        rampReset;
  logic        timer_rate_select;
  logic [2:0]  ramp_current_trim;
  logic [2:0]  auxSelect;
  int          thr [4] = '{default: 100000};
  int          period = 300;
  int          width = 40;
  int          mismatches = 0;
  int          compares = 0;
  int          cnt = 0;
  int          phase = 0;
  int          pw = 0;
  int          cap [4];
  bit          got [4];
  logic [31:0] seed = 32'h00014FB4;

  ssadc_timer dut_u (.core_clk, .nrst, .clkEn, .periodStart, .compTrip,
    .chanAcquiring, .regReq, .regRdata, .period_sync_pulse, .rampReset,
    .ramp_current_trim, .auxSelect, .timer_rate_select);
  ssadc_front front_u (.core_clk, .nrst, .rampReset, .period, .thr,
    .periodStart, .compTrip);

  initial
  begin
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    regReq <= '0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    regReq <= '0;
    @(negedge core_clk);
    check(regRdata, e);
  endtask

  // ==========================================================
  // reference timer and capture model
  always @(posedge core_clk)
  begin
    if (!nrst || (clkEn && period_sync_pulse))
    begin
      if (period_sync_pulse)
        pw++;
      cnt = 0;
      phase = 0;
      got = '{default: 1'b0};
    end
    else if (clkEn)
    begin
      if (pw > 0)
        check(16'(pw), 16'(width));
      pw = 0;
      for (int i = 0; i < 4; i++)
        if (compTrip[i] && !got[i])
        begin
          got[i] = 1'b1;
          cap[i] = cnt;
        end
      if (timer_rate_select || phase)
        cnt = (cnt < 4095) ? cnt + 1 : 4095;
      phase = !phase;
    end
    if (nrst)
      check(16'(rampReset), 16'(period_sync_pulse));
  end

  // ==========================================================
  // one two-period conversion run, results read late in the ramp
  task automatic conv(input bit fast, input int hold, input bit big);
    wr(OFF_MODE_CTRL, fast ? 16'h0080 : 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      thr[i] = (i == hold) ? 100000 : big ? 4100 + i * 30 : 1 + seed % 200;
    end
    chanAcquiring <= seed[7:4];
    repeat (2) @(posedge period_sync_pulse);
    repeat (width + (big ? 4210 : 210)) @(posedge core_clk);
    for (int i = 0; i < 4; i++)
      rdc(OFF_RESULT1 + 4'(i), got[i] ?
        16'(cap[i]) | 16'(chanAcquiring[i]) : 16'h0000);
    rdc(OFF_STATUS, 16'({ST_RAMP, got[3], got[2], got[1], got[0]}));
    $display("test conversion done rate %0d", fast);
  endtask

  initial
  begin
    logic [15:0] m;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rdc(OFF_MODE_CTRL, 16'h0000);
    rdc(OFF_SYNC_WIDTH, 16'h0028);
    rdc(OFF_TRIM, 16'h0000);
    rdc(4'h9, 16'h0000);
    check(16'(ramp_current_trim), 16'h0000);
    for (int v = 0; v < 8; v++)
    begin
      m = 16'h0000;
      m[5] = v[2];
      m[1] = v[1];
      m[0] = v[0];
      m[7] = v[0];
      wr(OFF_TRIM, 16'(v));
      wr(OFF_MODE_CTRL, m);
      rdc(OFF_TRIM, 16'(v));
      check(16'(ramp_current_trim), 16'(v));
      check(16'(auxSelect), 16'(v));
      check(16'(timer_rate_select), 16'(v[0]));
    end
    @(posedge core_clk);
    clkEn <= 1'b0;
    wr(OFF_TRIM, 16'h0002);
    clkEn <= 1'b1;
    rdc(OFF_TRIM, 16'h0007);
    check(16'(ramp_current_trim), 16'h0007);
    $display("test registers done");
    conv(1'b0, 3, 1'b0);
    conv(1'b1, 0, 1'b0);
    @(negedge period_sync_pulse);
    wr(OFF_SYNC_WIDTH, 16'h0005);
    width = 5;
    period = 4300;
    conv(1'b1, 3, 1'b1);
    end_sim;
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    end_sim;
  end
endmodule
